// *** dv/apb_host_model.sv ***
// APB host model issuing register commands
`default_nettype none
module apb_host_model (
   // Clock
   input  wire logic        clk,
   // APB master
   output logic [7:0]       paddr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
   end
   // Held until pready; afterwards paddr and pwdata show inverted values, while pwrite keeps its value
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// *** dv/sense_gain_memscan_cmd_checker.sv ***
// Port checks for the sense command block
`default_nettype none
module sense_gain_memscan_cmd_checker import sense_pkg::*; #(
   parameter int CHAN_W = 10,
   parameter int GAIN_W = 8
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Receiver side
   input wire func_set_t         active_functions,
   input wire logic              trace_record_clear,
   input wire logic [GAIN_W-1:0] manual_gain_value,
   input wire logic              memory_scan_active,
   input wire logic [CHAN_W-1:0] current_slot
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      pready ##1 !pready;
   endsequence
   AST_PREADY_TIMING: assert property (s_setup |=> s_access)
      else $error("pready not one cycle after setup");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready && penable)
      else $error("pslverr outside access");
   AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero when idle");
   AST_TRACE_CLEAR: assert property ($changed(active_functions)
      |-> ##[0:1] trace_record_clear)
      else $error("no trace clear on set change");
   AST_CLEAR_PULSE: assert property (trace_record_clear |=> !trace_record_clear)
      else $error("trace clear longer than one cycle");
   AST_GAIN_RANGE: assert property ($signed(manual_gain_value) >= -30
      && $signed(manual_gain_value) <= 110)
      else $error("gain out of range");
   AST_SLOT_RANGE: assert property (current_slot <= 999)
      else $error("slot out of range");
   // During a scan only the stepper may move the slot
   AST_SLOT_STEP: assert property ($past(memory_scan_active) && $changed(current_slot)
      |-> current_slot == $past(current_slot) + 1'b1 || current_slot == '0)
      else $error("slot moved other than by a step");
endmodule : sense_gain_memscan_cmd_checker
bind sense_gain_memscan_cmd sense_gain_memscan_cmd_checker #(
   .CHAN_W(CHAN_W),
   .GAIN_W(GAIN_W)
) sense_gain_memscan_cmd_checker_inst (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .active_functions(active_functions),
   .trace_record_clear(trace_record_clear), .manual_gain_value(manual_gain_value),
   .memory_scan_active(memory_scan_active), .current_slot(current_slot)
);
`default_nettype wire

// *** dv/sense_gain_memscan_cmd_test.sv ***
// Self-checking bench for the sense command block
`default_nettype none
`include "sense_regs.svh"
module sense_gain_memscan_cmd_test import sense_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, signal_in;
   logic        trace_record_clear, gain_fixed, memory_scan_active, irq, rerr;
   logic [7:0]  paddr, manual_gain_value;
   logic [31:0] pwdata, prdata, rdat;
   logic [9:0]  next_free_slot, current_slot;
   func_set_t   active_functions;
   int          fails, comparisons;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   apb_host_model apb_host_model_inst (.clk(clk), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   sense_gain_memscan_cmd sense_gain_memscan_cmd_inst (.clk(clk), .rst(rst),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .signal_in(signal_in), .next_free_slot(next_free_slot),
      .active_functions(active_functions), .trace_record_clear(trace_record_clear),
      .gain_fixed(gain_fixed), .manual_gain_value(manual_gain_value),
      .memory_scan_active(memory_scan_active), .current_slot(current_slot),
      .irq(irq));
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk1
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb_host_model_inst.xfer(a, 1'b1, d, rdat, rerr);
      chk1(rerr, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb_host_model_inst.xfer(a, 1'b0, 32'h0000_0000, rdat, rerr);
      chk1(rerr, 1'b0);
      chk32(rdat, x);
   endtask : rd
   task automatic settle;
      repeat (3) @(negedge clk);
   endtask : settle
   task automatic wait_scan(input logic v, input int n);
      for (int i = 0; i < n && memory_scan_active !== v; i++) @(negedge clk);
      chk1(memory_scan_active, v);
   endtask : wait_scan
   task automatic t_reset;
      rd(`OFS_CTRL, 32'h0000_0001);
      rd(`OFS_FUNC_OFF, 32'h0000_0006);
      rd(`OFS_FUNC_COUNT, 32'h0000_0201);
      rd(`OFS_GAIN, 32'h0000_0032);
      rd(`OFS_GAIN_STEP, 32'h0000_0001);
      rd(`OFS_SCAN_COUNT, 32'h8000_0001);
      rd(`OFS_HOLD, 32'h0000_0000);
      chk1(gain_fixed, 1'b0);
      apb_host_model_inst.xfer(8'h40, 1'b0, 32'h0000_0000, rdat, rerr);
      chk1(rerr, 1'b1);
      chk32(rdat, 32'h0000_0000);
   endtask : t_reset
   task automatic t_multi_on;
      wr(`OFS_FUNC_ON, 32'h0000_0002, 1'b0);
      rd(`OFS_FUNC_ON, 32'h0000_0003);
      rd(`OFS_FUNC_COUNT, 32'h0000_0102);
      wr(`OFS_FUNC_OFF, 32'h0000_0007, 1'b0);
      rd(`OFS_FUNC_ON, 32'h0000_0000);
      rd(`OFS_FUNC_COUNT, 32'h0000_0300);
   endtask : t_multi_on
   task automatic t_multi_off;
      wr(`OFS_FUNC_ON, 32'h0000_0006, 1'b0);
      wr(`OFS_CTRL, 32'h0000_0000, 1'b0);
      rd(`OFS_FUNC_ON, 32'h0000_0001);
      wr(`OFS_FUNC_ON, 32'h0000_0004, 1'b0);
      rd(`OFS_FUNC_OFF, 32'h0000_0003);
      wr(`OFS_INT_CLEAR, 32'h0000_000F, 1'b0);
      wr(`OFS_INT_ENABLE, 32'h0000_0001, 1'b0);
      wr(`OFS_FUNC_ON, 32'h0000_0003, 1'b1);
      rd(`OFS_ERR, 32'h0000_FF94);
      chk32({29'h0, active_functions}, 32'h0000_0004);
      chk1(irq, 1'b1);
      wr(`OFS_FUNC_ON, 32'h0000_0001, 1'b0);
      wr(`OFS_INT_CLEAR, 32'h0000_0001, 1'b0);
      settle;
      chk1(irq, 1'b0);
      rd(`OFS_INT_STATUS, 32'h0000_0002);
   endtask : t_multi_off
   task automatic t_gain;
      wr(`OFS_GAIN, 32'h0000_00C8, 1'b0);
      rd(`OFS_GAIN, 32'h0000_006E);
      wr(`OFS_GAIN_STEP, 32'h0000_000A, 1'b0);
      wr(`OFS_GAIN_CMD, 32'h0000_0002, 1'b0);
      rd(`OFS_GAIN, 32'h0000_0064);
      wr(`OFS_GAIN, 32'h0000_03E2, 1'b0);
      wr(`OFS_GAIN_CMD, 32'h0000_0002, 1'b0);
      rd(`OFS_GAIN, 32'hFFFF_FFE2);
      wr(`OFS_GAIN_CMD, 32'h0000_0003, 1'b0);
      rd(`OFS_GAIN, 32'hFFFF_FFEC);
      wr(`OFS_CTRL, 32'h0000_0002, 1'b0);
      settle;
      chk1(gain_fixed, 1'b1);
   endtask : t_gain
   task automatic t_scan;
      @(posedge clk);
      next_free_slot <= 10'h155;
      wr(`OFS_CHAN, 32'h0000_03E8, 1'b1);
      wr(`OFS_CHAN, 32'h0001_0000, 1'b0);
      rd(`OFS_CHAN, 32'h0000_0155);
      wr(`OFS_CHAN, 32'h0000_03E6, 1'b0);
      wr(`OFS_DWELL, 32'h0000_0002, 1'b0);
      wr(`OFS_SCAN_COUNT, 32'h0000_0001, 1'b0);
      wr(`OFS_CTRL, 32'h0000_0008, 1'b0);
      wr(`OFS_SCAN_CMD, 32'h0000_0001, 1'b0);
      rd(`OFS_SCAN_CMD, 32'h0000_0001);
      wr(`OFS_CHAN, 32'h0000_0005, 1'b1);
      wait_scan(1'b0, 400);
      chk32({22'h0, current_slot}, 32'h0000_0000);
      rd(`OFS_INT_STATUS, 32'h0000_000E);
   endtask : t_scan
   task automatic t_stop;
      wr(`OFS_CTRL, 32'h0000_000C, 1'b0);
      rd(`OFS_CTRL, 32'h0000_000C);
      wr(`OFS_DWELL, 32'h0000_0064, 1'b0);
      wr(`OFS_HOLD, 32'h0000_0001, 1'b0);
      wr(`OFS_SCAN_COUNT, 32'h8000_0000, 1'b0);
      wr(`OFS_CHAN, 32'h0000_0005, 1'b0);
      wr(`OFS_SCAN_CMD, 32'h0000_0001, 1'b0);
      @(posedge clk);
      signal_in <= 1'b0;
      // Dwell alone would take 4000 cycles; only the hold path fits the bound
      for (int i = 0; i < 300 && current_slot !== 10'h006; i++) @(negedge clk);
      chk32({22'h0, current_slot}, 32'h0000_0006);
      @(posedge clk);
      signal_in <= 1'b1;
      wr(`OFS_SCAN_CMD, 32'h0000_0002, 1'b0);
      wait_scan(1'b0, 20);
   endtask : t_stop
   task automatic finish_test;
      if (fails == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      fails = 0;
      comparisons = 0;
      rst = 1'b1;
      signal_in = 1'b1;
      next_free_slot = 10'h000;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_multi_on;
      t_multi_off;
      t_gain;
      t_scan;
      t_stop;
      finish_test;
   end
   initial begin
      #500000;
      fails++;
      finish_test;
   end
endmodule : sense_gain_memscan_cmd_test
`default_nettype wire

// *** hdl/scan_step_timer.sv ***
// Dwell and signal-loss hold timer for one memory-scan step
`default_nettype none
module scan_step_timer import sense_pkg::*; #(
   parameter int TIME_W = 20
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // Control
   input  wire logic              run,
   input  wire logic              tick,
   input  wire logic              stop_enable,
   input  wire logic              signal_present,
   input  wire logic [TIME_W-1:0] dwell,
   input  wire logic [TIME_W-1:0] hold,
   // Step request
   output logic                   step
);
   timer_state_t      state;
   logic [TIME_W-1:0] dwell_cnt;
   logic [TIME_W-1:0] hold_cnt;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= TIMER_IDLE;
         dwell_cnt <= '0;
         hold_cnt  <= '0;
         step      <= 1'b0;
      end else begin
         step <= 1'b0;
         unique case (state)
            TIMER_IDLE: begin
               if (run) begin
                  state     <= TIMER_DWELL;
                  dwell_cnt <= dwell;
               end
            end
            TIMER_DWELL, TIMER_HOLD: begin
               if (!run) begin
                  state <= TIMER_IDLE;
               end else if (dwell_cnt == '0) begin
                  step      <= 1'b1;
                  dwell_cnt <= dwell;
                  state     <= TIMER_DWELL;
               end else begin
                  if (tick) begin
                     dwell_cnt <= dwell_cnt - 1'b1;
                  end
                  if (state == TIMER_DWELL) begin
                     if (stop_enable && !signal_present) begin
                        state    <= TIMER_HOLD;
                        hold_cnt <= hold;
                     end
                  end else if (signal_present) begin
                     state <= TIMER_DWELL;
                  end else if (hold_cnt == '0) begin
                     step      <= 1'b1;
                     dwell_cnt <= dwell;
                     state     <= TIMER_DWELL;
                  end else if (tick) begin
                     hold_cnt <= hold_cnt - 1'b1;
                  end
               end
            end
            // The fourth code of the state word is unused; recover to idle
            default: state <= TIMER_IDLE;
         endcase
      end
   end
endmodule : scan_step_timer
`default_nettype wire

// *** hdl/sense_gain_memscan_cmd.sv ***
// APB command logic for measurement functions, manual gain and memory scan
// Notes on behaviour
// - Any change of the active function set discards the trace record.
// - Multi-select off: switching a function on makes it the only one.
// - Multi-select on: switch-on adds the written functions to the set; reset default on.
// - Multi-select on to off activates level only.
// - Multi-select off with two or more functions: reject, error -108.
// - Functions level, offset, field strength; reset leaves level active.
// - Active list reads in order level, offset, field strength; empty is zero.
// - Inactive list reads the deactivated functions.
// - Active and inactive function counts are readable.
// - Manual gain -30 to 110 dBuV, reset value 50.
// - Up and down move gain by the step; step resets to 1 dB.
// - Gain mode fixed or automatic; automatic after reset.
// - Scan mode selected, then initiate starts a scan over the slots.
// - Slot pointer 0 to 999 or next free; resets to 0; readable.
// - Signal-stop on: signal loss during dwell cuts the dwell short.
// - Scan controls off after reset; enabled and disabled sets readable.
// - Scan count is a number or infinite; infinite after reset.
// - Signal loss starts hold timer; expiry steps, return restarts; 0 s.
//
// Implementation choices: the register addresses and the APB slave port.
`default_nettype none
`include "sense_regs.svh"
module sense_gain_memscan_cmd import sense_pkg::*; #(
   parameter int CHAN_W  = 10,
   parameter int GAIN_W  = 8,
   parameter int COUNT_W = 16,
   parameter int TIME_W  = 20
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // APB slave
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Receiver side
   input  wire logic              signal_in,
   input  wire logic [CHAN_W-1:0] next_free_slot,
   output func_set_t              active_functions,
   output logic                   trace_record_clear,
   output logic                   gain_fixed,
   output logic [GAIN_W-1:0]      manual_gain_value,
   output logic                   memory_scan_active,
   output logic [CHAN_W-1:0]      current_slot,
   output logic                   irq
);
   localparam logic [GAIN_W-1:0] GAIN_LO = GAIN_W'(`GAIN_MIN);
   localparam logic [GAIN_W-1:0] GAIN_HI = GAIN_W'(`GAIN_MAX);
   localparam logic [CHAN_W-1:0] LAST   = CHAN_W'(`CHAN_LAST);
   localparam int                TICKS  = `TICK_CYCLES;

   function automatic logic [1:0] count_set(input logic [2:0] f);
      count_set = {1'b0, f[0]} + {1'b0, f[1]} + {1'b0, f[2]};
   endfunction : count_set

   function automatic logic [GAIN_W-1:0] clamp_gain(input logic signed [GAIN_W+1:0] v);
      if (v < $signed({{2{GAIN_LO[GAIN_W-1]}}, GAIN_LO})) begin
         clamp_gain = GAIN_LO;
      end else if (v > $signed({2'b00, GAIN_HI})) begin
         clamp_gain = GAIN_HI;
      end else begin
         clamp_gain = v[GAIN_W-1:0];
      end
   endfunction : clamp_gain

   // Bus decode
   logic        setup;
   logic        wr;
   logic        mapped;
   logic        bad_on;
   logic        bad_chan;
   logic        refuse;
   // Control bits
   logic        multi_select;
   logic        stop_signal;
   logic        memory_scan_mode;
   // Gain step and scan configuration
   logic [GAIN_W-1:0]  gain_step;
   logic               count_inf;
   logic [COUNT_W-1:0] count_val;
   logic [COUNT_W-1:0] remaining;
   logic [TIME_W-1:0]  dwell;
   logic [TIME_W-1:0]  hold;
   // Status
   logic [15:0] err_code;
   logic [3:0]  int_status;
   logic [3:0]  int_enable;
   logic        ev_err;
   logic        ev_func;
   logic        ev_step;
   logic        ev_done;
   // Signal synchroniser, tick and timer
   logic [2:0]  sig_sync;
   logic        signal_present;
   logic [7:0]  tick_cnt;
   logic        tick;
   logic        step;
   func_set_t   next_active;

   assign setup = psel && !penable;
   assign wr    = psel && penable && pready && pwrite;

   always_comb begin
      unique case (paddr)
         `OFS_CTRL, `OFS_FUNC_ON, `OFS_FUNC_OFF, `OFS_FUNC_COUNT, `OFS_GAIN,
         `OFS_GAIN_STEP, `OFS_GAIN_CMD, `OFS_CHAN, `OFS_SCAN_COUNT, `OFS_SCAN_CMD,
         `OFS_ERR, `OFS_INT_STATUS, `OFS_INT_CLEAR, `OFS_INT_ENABLE, `OFS_DWELL,
         `OFS_HOLD: mapped = 1'b1;
         default:   mapped = 1'b0;
      endcase
   end

   assign bad_on = pwrite && paddr == `OFS_FUNC_ON && !multi_select
                   && count_set(pwdata[2:0]) > 2'd1;
   // Slot writes during a scan, or beyond the last slot, are refused
   assign bad_chan = pwrite && paddr == `OFS_CHAN && (memory_scan_active
                     || (!pwdata[`CHAN_NEXT_FREE] && pwdata[CHAN_W-1:0] > LAST));
   assign refuse = !mapped || bad_on || bad_chan;

   // APB: no wait states, read data and error captured in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && refuse;
         prdata  <= 32'h0000_0000;
         if (setup && !pwrite) begin
            unique case (paddr)
               `OFS_CTRL: prdata <= {28'h000_0000, memory_scan_mode, stop_signal, gain_fixed,
                                     multi_select};
               `OFS_FUNC_ON:  prdata <= {29'h0000_0000, active_functions};
               `OFS_FUNC_OFF: prdata <= {29'h0000_0000, ~active_functions};
               `OFS_FUNC_COUNT: begin
                  prdata[1:0] <= count_set(active_functions);
                  prdata[`INACTIVE_LSB +: 2] <= count_set(~active_functions);
               end
               `OFS_GAIN: prdata <= {{(32-GAIN_W){manual_gain_value[GAIN_W-1]}},
                                     manual_gain_value};
               `OFS_GAIN_STEP: prdata[GAIN_W-1:0] <= gain_step;
               `OFS_CHAN:      prdata[CHAN_W-1:0] <= current_slot;
               `OFS_SCAN_COUNT: begin
                  prdata[`COUNT_INF]   <= count_inf;
                  prdata[COUNT_W-1:0] <= count_val;
               end
               `OFS_SCAN_CMD:   prdata[0] <= memory_scan_active;
               `OFS_ERR:        prdata[15:0] <= err_code;
               `OFS_INT_STATUS: prdata[3:0] <= int_status;
               `OFS_INT_ENABLE: prdata[3:0] <= int_enable;
               `OFS_DWELL:      prdata[TIME_W-1:0] <= dwell;
               `OFS_HOLD:       prdata[TIME_W-1:0] <= hold;
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Control bits
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         multi_select <= 1'b1;
         gain_fixed   <= 1'b0;
         stop_signal  <= 1'b0;
         memory_scan_mode   <= 1'b0;
      end else if (wr && paddr == `OFS_CTRL) begin
         multi_select <= pwdata[`CTRL_MULTI];
         gain_fixed   <= pwdata[`CTRL_GAIN_FIX];
         stop_signal  <= pwdata[`CTRL_STOP_SIG];
         memory_scan_mode   <= pwdata[`CTRL_MEMORY_SCAN_MODE];
      end
   end

   // Next function set from the current write
   always_comb begin
      next_active = active_functions;
      if (wr && paddr == `OFS_FUNC_ON && !bad_on) begin
         if (multi_select) begin
            next_active = active_functions | func_set_t'(pwdata[2:0]);
         end else if (pwdata[2:0] != 3'b000) begin
            next_active = func_set_t'(pwdata[2:0]);
         end
      end else if (wr && paddr == `OFS_FUNC_OFF) begin
         next_active = active_functions & ~func_set_t'(pwdata[2:0]);
      end else if (wr && paddr == `OFS_CTRL && multi_select && !pwdata[`CTRL_MULTI]) begin
         next_active = '{field_strength: 1'b0, offset: 1'b0, level: 1'b1};
      end
   end

   // Function set, trace discard and parameter error
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         active_functions   <= '{field_strength: 1'b0, offset: 1'b0, level: 1'b1};
         trace_record_clear <= 1'b0;
         ev_func            <= 1'b0;
         ev_err             <= 1'b0;
         err_code           <= 16'h0000;
      end else begin
         active_functions   <= next_active;
         trace_record_clear <= next_active != active_functions;
         ev_func            <= next_active != active_functions;
         ev_err             <= wr && bad_on;
         if (wr && bad_on) begin
            err_code <= `ERR_PARAM;
         end
      end
   end

   // Manual gain value and step; saturates at the range ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         manual_gain_value <= GAIN_W'(`GAIN_RST);
         gain_step         <= GAIN_W'(`STEP_RST);
      end else if (wr) begin
         if (paddr == `OFS_GAIN) begin
            manual_gain_value <= clamp_gain(pwdata[GAIN_W+1:0]);
         end else if (paddr == `OFS_GAIN_STEP) begin
            gain_step <= pwdata[GAIN_W-1:0];
         end else if (paddr == `OFS_GAIN_CMD && pwdata[`CMD_UP]) begin
            manual_gain_value <= clamp_gain($signed({{2{manual_gain_value[GAIN_W-1]}},
                                 manual_gain_value}) + $signed({2'b00, gain_step}));
         end else if (paddr == `OFS_GAIN_CMD && pwdata[`CMD_DOWN]) begin
            manual_gain_value <= clamp_gain($signed({{2{manual_gain_value[GAIN_W-1]}},
                                 manual_gain_value}) - $signed({2'b00, gain_step}));
         end
      end
   end

   // Scan configuration
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_inf <= 1'b1;
         count_val <= COUNT_W'(`COUNT_RST);
         dwell     <= TIME_W'(`DWELL_RST_US);
         hold      <= TIME_W'(`HOLD_RST_US);
      end else if (wr) begin
         if (paddr == `OFS_SCAN_COUNT) begin
            count_inf <= pwdata[`COUNT_INF];
            count_val <= pwdata[COUNT_W-1:0];
         end else if (paddr == `OFS_DWELL) begin
            dwell <= pwdata[TIME_W-1:0];
         end else if (paddr == `OFS_HOLD) begin
            hold <= pwdata[TIME_W-1:0];
         end
      end
   end

   // Slot pointer and scan run state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         current_slot       <= '0;
         memory_scan_active <= 1'b0;
         remaining          <= '0;
         ev_step            <= 1'b0;
         ev_done            <= 1'b0;
      end else begin
         ev_step <= 1'b0;
         ev_done <= 1'b0;
         if (wr && paddr == `OFS_CHAN && !bad_chan) begin
            current_slot <= pwdata[`CHAN_NEXT_FREE] ? next_free_slot
                                                    : pwdata[CHAN_W-1:0];
         end
         if (!memory_scan_active) begin
            if (wr && paddr == `OFS_SCAN_CMD && pwdata[`CMD_INITIATE] && memory_scan_mode) begin
               memory_scan_active <= 1'b1;
               remaining          <= count_val;
            end
         end else if ((wr && paddr == `OFS_SCAN_CMD && pwdata[`CMD_ABORT]) || !memory_scan_mode) begin
            memory_scan_active <= 1'b0;
            ev_done            <= 1'b1;
         end else if (step) begin
            ev_step <= 1'b1;
            if (current_slot == LAST) begin
               current_slot <= '0;
               // A count of zero still runs one full pass
               if (!count_inf && remaining <= COUNT_W'(1)) begin
                  memory_scan_active <= 1'b0;
                  ev_done            <= 1'b1;
               end else if (!count_inf) begin
                  remaining <= remaining - 1'b1;
               end
            end else begin
               current_slot <= current_slot + 1'b1;
            end
         end
      end
   end

   // Interrupt status: a new event wins over a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         int_status <= 4'h0;
         int_enable <= 4'h0;
         irq        <= 1'b0;
      end else begin
         int_status <= (int_status & ~((wr && paddr == `OFS_INT_CLEAR) ? pwdata[3:0] : 4'h0))
                       | {ev_done, ev_step, ev_func, ev_err};
         if (wr && paddr == `OFS_INT_ENABLE) begin
            int_enable <= pwdata[3:0];
         end
         irq <= |(int_status & int_enable);
      end
   end

   // Signal pin: a change counts once the last two stages agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sig_sync       <= 3'b000;
         signal_present <= 1'b0;
      end else begin
         sig_sync <= {sig_sync[1:0], signal_in};
         if (sig_sync[1] == sig_sync[2]) begin
            signal_present <= sig_sync[2];
         end
      end
   end

   // Microsecond tick for the step timer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 8'h00;
         tick     <= 1'b0;
      end else begin
         tick     <= tick_cnt == 8'(TICKS - 1);
         tick_cnt <= (tick_cnt == 8'(TICKS - 1)) ? 8'h00 : tick_cnt + 1'b1;
      end
   end

   scan_step_timer #(
      .TIME_W (TIME_W)
   ) u_timer (
      .clk            (clk),
      .rst            (rst),
      .run            (memory_scan_active),
      .tick           (tick),
      .stop_enable    (stop_signal),
      .signal_present (signal_present),
      .dwell          (dwell),
      .hold           (hold),
      .step           (step)
   );
endmodule : sense_gain_memscan_cmd
`default_nettype wire

// *** hdl/sense_pkg.sv ***
// Types shared by the sense, gain and memory-scan command logic
`default_nettype none
package sense_pkg;
   typedef struct packed {
      logic field_strength;
      logic offset;
      logic level;
   } func_set_t;
   typedef enum logic [1:0] {
      TIMER_IDLE,
      TIMER_DWELL,
      TIMER_HOLD
   } timer_state_t;
endpackage : sense_pkg
`default_nettype wire

// *** hdl/sense_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef SENSE_REGS_SVH
`define SENSE_REGS_SVH
// Byte offsets on the APB
`define OFS_CTRL        8'h00
`define OFS_FUNC_ON     8'h04
`define OFS_FUNC_OFF    8'h08
`define OFS_FUNC_COUNT  8'h0C
`define OFS_GAIN        8'h10
`define OFS_GAIN_STEP   8'h14
`define OFS_GAIN_CMD    8'h18
`define OFS_CHAN        8'h1C
`define OFS_SCAN_COUNT  8'h20
`define OFS_SCAN_CMD    8'h24
`define OFS_ERR         8'h28
`define OFS_INT_STATUS  8'h2C
`define OFS_INT_CLEAR   8'h30
`define OFS_INT_ENABLE  8'h34
`define OFS_DWELL       8'h38
`define OFS_HOLD        8'h3C
// Field positions
`define CTRL_MULTI      0
`define CTRL_GAIN_FIX   1
`define CTRL_STOP_SIG   2
`define CTRL_MEMORY_SCAN_MODE 3
`define CMD_UP          0
`define CMD_DOWN        1
`define CMD_INITIATE    0
`define CMD_ABORT       1
`define CHAN_NEXT_FREE  16
`define COUNT_INF       31
`define INACTIVE_LSB    8
`define INT_ERR         0
`define INT_FUNC        1
`define INT_STEP        2
`define INT_DONE        3
// Reset values and limits
`define GAIN_RST        8'h32
`define GAIN_MIN        8'hE2
`define GAIN_MAX        8'h6E
`define STEP_RST        8'h01
`define CHAN_LAST       10'h3E7
`define ERR_PARAM       16'hFF94
`define COUNT_RST       16'h0001
`define DWELL_RST_US    20'h7_A120
`define HOLD_RST_US     20'h0_0000
// Timing: the step timer counts in microseconds
`define CLK_PERIOD_NS   25
`define TICK_NS         1000
`define TICK_CYCLES     ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif
